// File: cv_set_hard_reset_loader_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cv_set_hard_reset_loader_tb;
	// ********************************************************
	// Signals
	// ********************************************************
	logic ref_clk = 1'b0; // 20 MHz clock
	logic rst_n = 1'b0; // Reset, active low
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [10:0] wb_adr_i = 11'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [7:0] nv_last_set;
	logic nv_store;
	logic [7:0] nv_store_data;
	int miscompares = 0; // Mismatches
	int checks = 0; // Comparisons made
	int cycles = 0; // Watchdog count
	logic [31:0] q; // Last read word
	logic [7:0] cur; // Set applied by the row loop
	// Rows: set number, variable index, expected value
	localparam logic [23:0] ROWS [0:46] = '{
		24'h0b0303, 24'h0b0402, 24'h0b0958, 24'h0b0d01, 24'h0b383d,
		24'h0b3aaa, 24'h0b7024, 24'h0b7c80, 24'h0b9840, 24'h0b0200,
		24'h0c030f, 24'h0c0408, 24'h0c0678, 24'h0c230c, 24'h0c2430,
		24'h0c7c02, 24'h0c7f02, 24'h0c8001, 24'h0c81aa, 24'h0c8224,
		24'h0c9b04, 24'h0c9c04, 24'h0c0900,
		24'h0d030a, 24'h0d0407, 24'h0d2300, 24'h0d2400, 24'h0d2500,
		24'h0d3d61, 24'h0d7c04, 24'h0d9b04, 24'h0d9c04, 24'h0d0600,
		24'h0e0204, 24'h0e0306, 24'h0e0402, 24'h0e05fc, 24'h0e0655,
		24'h0e095f, 24'h0e0a80, 24'h0e3821, 24'h0e7040, 24'h0e71ff,
		24'h0e7a1f, 24'h0e9080, 24'h0e921e, 24'h0e96ff};
	localparam logic [7:0] SETS [0:20] = '{8'h0e, 8'h0f, 8'h10, 8'h11,
		8'h12, 8'h13, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c,
		8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h27, 8'h28, 8'h0b};
	localparam logic [7:0] REJ [0:5] = '{8'h09, 8'h0a, 8'h14, 8'h15,
		8'h22, 8'h29};
	// ********************************************************
	// Design, retained storage and clock
	// ********************************************************
	cvl_loader uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.nv_last_set(nv_last_set), .nv_store(nv_store),
		.nv_store_data(nv_store_data));
	cvl_nv_model nv (.ref_clk(ref_clk), .nv_store(nv_store),
		.nv_store_data(nv_store_data), .nv_last_set(nv_last_set));
	always #25 ref_clk = ~ref_clk;
	// ********************************************************
	// Tasks
	// ********************************************************
	task automatic give_verdict;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// One classic cycle; holds until ack is sampled high
	task automatic wb(input logic we, input logic [10:0] adr,
		input logic [7:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= {24'h0, d};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	function automatic logic [10:0] a(input logic [7:0] idx);
		return {1'b0, idx, 2'b00};
	endfunction : a
	// Poll status until no walk runs
	task automatic wait_walk;
		logic [31:0] s;
		s = 32'h1;
		while (s[cvl_pkg::STATUS_BUSY_BIT] !== 1'b0) begin
			wb(1'b0, cvl_pkg::STATUS_ADDR, 8'h00, s);
		end
	endtask : wait_walk
	task automatic cmd(input logic [7:0] v);
		wb(1'b1, a(cvl_pkg::MAKER_VAR), v, q);
		wait_walk();
	endtask : cmd
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
		wb(1'b0, a(idx), 8'h00, q);
		chk(q, {24'h0, e});
	endtask : rd_chk
	task automatic set_chk(input logic [7:0] e);
		wb(1'b0, cvl_pkg::STATUS_ADDR, 8'h00, q);
		chk({24'h0, q[cvl_pkg::STATUS_SET_LSB +: 8]}, {24'h0, e});
	endtask : set_chk
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask : do_reset
	// Watchdog on the whole run
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ********************************************************
	// Sequence
	// ********************************************************
	initial begin
		do_reset();
		rd_chk(cvl_pkg::MAKER_VAR, cvl_pkg::MAKER_CODE);
		set_chk(8'h0d);
		rd_chk(8'h03, cvl_pkg::FACTORY_DEFAULT);
		cmd(cvl_pkg::CMD_REAPPLY);
		rd_chk(8'h3d, 8'h61);
		// Preset rows, switching set when the row's set changes
		cur = 8'h00;
		foreach (ROWS[i]) begin
			if (ROWS[i][23:16] != cur) begin
				cur = ROWS[i][23:16];
				cmd(cur);
			end
			rd_chk(ROWS[i][15:8], ROWS[i][7:0]);
		end
		chk({24'h0, nv.retained_reg}, 32'h0e);
		// Byte from bit weights: bits 0, 2, 4 and 5
		wb(1'b1, a(8'h70), 8'h01 + 8'h04 + 8'h10 + 8'h20, q);
		rd_chk(8'h70, 8'h35);
		wb(1'b1, a(cvl_pkg::MAKER_VAR), 8'h33, q);
		rd_chk(cvl_pkg::MAKER_VAR, cvl_pkg::MAKER_CODE);
		rd_chk(8'h70, 8'h35);
		foreach (SETS[i]) begin
			cmd(SETS[i]);
			set_chk(SETS[i]);
		end
		foreach (REJ[i]) begin
			cmd(REJ[i]);
			set_chk(8'h0b);
		end
		cmd(cvl_pkg::CMD_REAPPLY);
		rd_chk(8'h3a, 8'haa);
		cmd(cvl_pkg::CMD_FACTORY);
		set_chk(cvl_pkg::NO_SET);
		rd_chk(8'h3a, cvl_pkg::FACTORY_DEFAULT);
		// Unmapped word acks, reads zero
		wb(1'b1, 11'h408, 8'hff, q);
		wb(1'b0, 11'h408, 8'h00, q);
		chk(q, 32'h0);
		// Sound variant ignores preset numbers
		cmd(8'h0c);
		wb(1'b1, cvl_pkg::CTRL_ADDR, 8'h01, q);
		wb(1'b0, cvl_pkg::CTRL_ADDR, 8'h00, q);
		chk(q, 32'h1);
		wb(1'b1, a(8'h03), 8'h05, q);
		cmd(8'h0b);
		set_chk(8'h0c);
		rd_chk(8'h03, 8'h05);
		cmd(cvl_pkg::CMD_REAPPLY);
		rd_chk(8'h03, cvl_pkg::FACTORY_DEFAULT);
		// Record survives a reset through retained storage
		do_reset();
		wb(1'b0, cvl_pkg::CTRL_ADDR, 8'h00, q);
		chk(q, {31'h0, cvl_pkg::CTRL_SOUND_RESET});
		set_chk(8'h0c);
		cmd(cvl_pkg::CMD_REAPPLY);
		rd_chk(8'h06, 8'h78);
		give_verdict();
	end
endmodule : cv_set_hard_reset_loader_tb
`default_nettype wire

// File: cvl_loader.sv
// What this block does
// - Maker variable reads fixed code, never stored
// - Preset number write walks set plus defaults
// - Value 8 reapplies last set, defaults elsewhere
// - Value 0 loads plain factory defaults only
// - Ordinary variable writes stored when the low byte lane is enabled
// - Sound variant: reset uses defaults, no sets
// - Set 11 table values
// - Set 12 table values
// - Set 13 table values
// - Sets 14-19, 22-33, 39, 40 accepted
// - Shared vehicle group table values
// - Byte value is sum of bit weights
`timescale 1ns/10ps
`default_nettype none
module cvl_loader (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [10:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] nv_last_set,
	output logic nv_store,
	output logic [7:0] nv_store_data
);
	// ********************************************************
	// State
	// ********************************************************
	cvl_pkg::cvl_state_t state_reg; // Idle or walking the table
	logic [7:0] mem [cvl_pkg::VAR_COUNT]; // Variable storage
	logic [7:0] walk_idx_reg; // Variable being rewritten
	logic [7:0] walk_set_reg; // Set applied by the walk
	logic [7:0] last_set_reg; // Set applied by the last set or factory hard reset
	logic nv_loaded_reg; // Retained record has been fetched
	logic sound_reg; // Sound variant selected
	logic ack_reg; // Bus answer
	logic [31:0] dat_reg; // Bus read data
	logic nv_store_reg; // Record update pulse
	logic [7:0] nv_data_reg; // Record value to retain

	// ********************************************************
	// Bus decode
	// ********************************************************
	logic walking; // Walk in progress
	logic var_hit; // Access falls in the variable table
	logic ctrl_hit; // Access to control word
	logic status_hit; // Access to status word
	logic [7:0] bus_idx; // Variable index from address
	logic req_take; // Request answered at this edge
	logic wr_lane0; // Write with low byte enabled
	logic maker_cmd; // Action write to maker variable
	logic [7:0] cmd_value; // Action value
	logic cmd_set_valid; // Action value names a known set
	logic start_go; // Hard reset starts
	logic [7:0] start_set; // Set the new walk applies
	logic record_upd; // Retained record changes

	assign walking = (state_reg == cvl_pkg::CVL_WALK);
	assign bus_idx = wb_adr_i[9:2];
	assign var_hit = ~wb_adr_i[cvl_pkg::VAR_SEL_BIT];
	assign ctrl_hit = (wb_adr_i[10:2] == cvl_pkg::CTRL_ADDR[10:2]);
	assign status_hit = (wb_adr_i[10:2] == cvl_pkg::STATUS_ADDR[10:2]);
	// Status stays readable during a walk; all else waits for it
	assign req_take = wb_cyc_i & wb_stb_i & ~ack_reg & nv_loaded_reg &
		(~walking | status_hit);
	assign wr_lane0 = req_take & wb_we_i & wb_sel_i[0];
	// Bits keep their binary weights: byte lane taken as is
	assign cmd_value = wb_dat_i[7:0];
	assign maker_cmd = wr_lane0 & var_hit & (bus_idx == cvl_pkg::MAKER_VAR);

	// ********************************************************
	// Action decode
	// ********************************************************
	cvl_preset_table u_cmd_table (
		.set_num(cmd_value),
		.var_idx(cvl_pkg::MAKER_VAR),
		.set_valid(cmd_set_valid),
		.hit(),
		.value()
	);

	// Which values start a walk, and with which set
	always_comb begin
		start_go = 1'b0;
		start_set = cvl_pkg::NO_SET;
		if (maker_cmd) begin
			if (cmd_value == cvl_pkg::CMD_FACTORY) begin
				start_go = 1'b1;
			end else if (cmd_value == cvl_pkg::CMD_REAPPLY) begin
				start_go = 1'b1;
				// Sound variant: project defaults, never a set
				start_set = sound_reg ? cvl_pkg::NO_SET : last_set_reg;
			end else if (cmd_set_valid && !sound_reg) begin
				start_go = 1'b1;
				start_set = cmd_value;
			end
		end
	end

	// Record changes on every hard reset except the reapply
	assign record_upd = start_go && (cmd_value != cvl_pkg::CMD_REAPPLY);

	// ********************************************************
	// Walk sequencer
	// ********************************************************
	// Idle until an action, then one variable per cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= cvl_pkg::CVL_IDLE;
		end else begin
			unique case (state_reg)
				cvl_pkg::CVL_IDLE: begin
					if (start_go) begin
						state_reg <= cvl_pkg::CVL_WALK;
					end
				end
				cvl_pkg::CVL_WALK: begin
					if (walk_idx_reg == cvl_pkg::LAST_WALK_IDX) begin
						state_reg <= cvl_pkg::CVL_IDLE;
					end
				end
			endcase
		end
	end

	// Walk index runs over the whole table
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			walk_idx_reg <= 8'h00;
		end else if (start_go) begin
			walk_idx_reg <= 8'h00;
		end else if (walking) begin
			walk_idx_reg <= walk_idx_reg + 8'h01;
		end
	end

	// Set captured for the whole walk
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			walk_set_reg <= cvl_pkg::NO_SET;
		end else if (start_go) begin
			walk_set_reg <= start_set;
		end
	end

	// ********************************************************
	// Retained record of the applied set
	// ********************************************************
	// Fetched once after reset release, then follows set and factory hard resets
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			last_set_reg <= cvl_pkg::LAST_SET_RESET;
			nv_loaded_reg <= 1'b0;
		end else if (!nv_loaded_reg) begin
			last_set_reg <= nv_last_set;
			nv_loaded_reg <= 1'b1;
		end else if (record_upd) begin
			last_set_reg <= start_set;
		end
	end

	// Store request towards retained storage
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			nv_store_reg <= 1'b0;
			nv_data_reg <= cvl_pkg::LAST_SET_RESET;
		end else begin
			nv_store_reg <= record_upd;
			if (record_upd) begin
				nv_data_reg <= start_set;
			end
		end
	end

	// ********************************************************
	// Variable storage
	// ********************************************************
	logic tab_hit; // Walked variable belongs to the set
	logic [7:0] tab_value; // Set value of walked variable
	logic [7:0] walk_val; // Value written by the walk
	logic mem_we; // Storage write
	logic [7:0] mem_idx; // Storage write index
	logic [7:0] mem_wdata; // Storage write data

	cvl_preset_table u_walk_table (
		.set_num(walk_set_reg),
		.var_idx(walk_idx_reg),
		.set_valid(),
		.hit(tab_hit),
		.value(tab_value)
	);

	// Set value where the set has one, else factory default
	assign walk_val = tab_hit ? tab_value : cvl_pkg::FACTORY_DEFAULT;

	// Walk owns storage while active; bus writes otherwise
	always_comb begin
		if (walking) begin
			mem_we = (walk_idx_reg != cvl_pkg::MAKER_VAR);
			mem_idx = walk_idx_reg;
			mem_wdata = walk_val;
		end else begin
			mem_we = wr_lane0 & var_hit & (bus_idx != cvl_pkg::MAKER_VAR);
			mem_idx = bus_idx;
			mem_wdata = cmd_value;
		end
	end

	// Storage flip-flops
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < cvl_pkg::VAR_COUNT; i++) begin
				mem[i] <= cvl_pkg::FACTORY_DEFAULT;
			end
		end else if (mem_we) begin
			mem[mem_idx] <= mem_wdata;
		end
	end

	// ********************************************************
	// Control register
	// ********************************************************
	// Variant select, writable only outside a walk
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sound_reg <= cvl_pkg::CTRL_SOUND_RESET;
		end else if (wr_lane0 && ctrl_hit) begin
			sound_reg <= wb_dat_i[cvl_pkg::CTRL_SOUND_BIT];
		end
	end

	// ********************************************************
	// Bus answer
	// ********************************************************
	// Answer one cycle after the request is taken, for one cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req_take;
		end
	end

	// Read data; unmapped words read as zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dat_reg <= 32'h0000_0000;
		end else if (req_take) begin
			dat_reg <= 32'h0000_0000;
			if (!wb_we_i && var_hit) begin
				if (bus_idx == cvl_pkg::MAKER_VAR) begin
					dat_reg[7:0] <= cvl_pkg::MAKER_CODE;
				end else begin
					dat_reg[7:0] <= mem[bus_idx];
				end
			end else if (!wb_we_i && ctrl_hit) begin
				dat_reg[cvl_pkg::CTRL_SOUND_BIT] <= sound_reg;
			end else if (!wb_we_i && status_hit) begin
				dat_reg[cvl_pkg::STATUS_BUSY_BIT] <= walking;
				dat_reg[cvl_pkg::STATUS_SET_LSB +: 8] <= last_set_reg;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign nv_store = nv_store_reg;
	assign nv_store_data = nv_data_reg;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_start;
		start_go;
	endsequence

	sequence s_walk_run;
		walking [*8];
	endsequence

	maker_read_a: assert property (
		req_take && !wb_we_i && var_hit && bus_idx == cvl_pkg::MAKER_VAR
		|=> wb_ack_o && wb_dat_o == {24'h000000, cvl_pkg::MAKER_CODE})
		else $error("maker variable read wrong");

	maker_kept_a: assert property (
		!(mem_we && mem_idx == cvl_pkg::MAKER_VAR))
		else $error("maker variable written");

	walk_runs_a: assert property (
		s_start |=> s_walk_run ##[1:300] !walking)
		else $error("hard reset walk length wrong");

	reapply_set_a: assert property (
		(s_start and (cmd_value == cvl_pkg::CMD_REAPPLY && !sound_reg))
		|=> walk_set_reg == $past(last_set_reg))
		else $error("reapply used wrong set");

	factory_set_a: assert property (
		(s_start and (cmd_value == cvl_pkg::CMD_FACTORY))
		|=> walk_set_reg == cvl_pkg::NO_SET && last_set_reg == 8'h00)
		else $error("factory reset kept a set");

	bus_store_a: assert property (
		!walking && wr_lane0 && var_hit && bus_idx != cvl_pkg::MAKER_VAR
		|=> mem[$past(bus_idx)] == $past(cmd_value))
		else $error("variable write lost");

	sound_noset_a: assert property (
		sound_reg && maker_cmd
		|=> walk_set_reg == cvl_pkg::NO_SET || !walking)
		else $error("set applied in sound variant");

	set11_val_a: assert property (
		walking && walk_set_reg == 8'h0b && walk_idx_reg == 8'h09
		|=> mem[8'h09] == 8'h58)
		else $error("set 11 value wrong");

	set12_val_a: assert property (
		walking && walk_set_reg == 8'h0c && walk_idx_reg == 8'h06
		|=> mem[8'h06] == 8'h78)
		else $error("set 12 value wrong");

	set13_val_a: assert property (
		walking && walk_set_reg == 8'h0d && walk_idx_reg == 8'h3d
		|=> mem[8'h3d] == 8'h61)
		else $error("set 13 value wrong");

	extra_sets_a: assert property (
		maker_cmd && !sound_reg && cmd_value inside {8'h0e, 8'h21, 8'h28}
		|-> start_go)
		else $error("listed set refused");

	group_val_a: assert property (
		walking && walk_set_reg == 8'h16 && walk_idx_reg == 8'h05
		|=> mem[8'h05] == 8'hfc)
		else $error("group value wrong");

	record_a: assert property (
		record_upd |=> nv_store && nv_store_data == $past(start_set)
		##1 !nv_store)
		else $error("record store wrong");
endmodule : cvl_loader
`default_nettype wire

// File: cvl_nv_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************
// Retained storage for the last applied set number
// ********************************************************
module cvl_nv_model #(
	parameter logic [7:0] INIT_SET = 8'h0d // Contents at power-up
) (
	input wire logic ref_clk,
	input wire logic nv_store,
	input wire logic [7:0] nv_store_data,
	output logic [7:0] nv_last_set
);
	// Survives the loader's reset, like real retained memory
	logic [7:0] retained_reg = INIT_SET;
	// Capture on the store pulse only
	always @(posedge ref_clk) begin
		if (nv_store) begin
			retained_reg <= nv_store_data;
		end
	end
	// Always presented to the loader
	assign nv_last_set = retained_reg;
endmodule : cvl_nv_model
`default_nettype wire

// File: cvl_pkg.sv
`default_nettype none
package cvl_pkg;
	// ********************************************************
	// Bus map
	// ********************************************************
	localparam int ADDR_W = 11;                  // Byte address width
	localparam logic [10:0] CTRL_ADDR = 11'h400;   // Control word
	localparam logic [10:0] STATUS_ADDR = 11'h404; // Status word
	localparam int VAR_SEL_BIT = 10;             // Low half is the table
	localparam int CTRL_SOUND_BIT = 0;           // Sound variant select
	localparam int STATUS_BUSY_BIT = 0;          // Walk in progress
	localparam int STATUS_SET_LSB = 8;           // Last applied set
	// ********************************************************
	// Variables and commands
	// ********************************************************
	localparam int VAR_COUNT = 256;              // Stored variables
	localparam logic [7:0] MAKER_VAR = 8'h08;    // Maker code variable
	localparam logic [7:0] MAKER_CODE = 8'h5a;   // Arbitrary neutral code
	localparam logic [7:0] FACTORY_DEFAULT = 8'h00; // Plain default
	localparam logic [7:0] CMD_FACTORY = 8'h00;  // Plain factory reset
	localparam logic [7:0] CMD_REAPPLY = 8'h08;  // Standard reset
	localparam logic [7:0] NO_SET = 8'h00;       // No preset applied
	localparam logic [7:0] LAST_WALK_IDX = 8'hff; // Final walk index
	localparam logic [7:0] LAST_SET_RESET = 8'h00; // Record after reset
	localparam logic CTRL_SOUND_RESET = 1'b0;    // Non-sound after reset
	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic {CVL_IDLE, CVL_WALK} cvl_state_t;
endpackage : cvl_pkg
`default_nettype wire

// File: cvl_preset_table.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************
// Preset set lookup: value of one variable in one set
// ********************************************************
module cvl_preset_table (
	input wire logic [7:0] set_num,
	input wire logic [7:0] var_idx,
	output logic set_valid,
	output logic hit,
	output logic [7:0] value
);
	logic common; // Set belongs to the shared vehicle group

	// Accepted set numbers
	always_comb begin
		common = (set_num inside {[8'h0e:8'h13], [8'h16:8'h21],
			8'h27, 8'h28});
		set_valid = common || (set_num inside {[8'h0b:8'h0d]});
	end

	// Table contents
	always_comb begin
		hit = 1'b1;
		value = cvl_pkg::FACTORY_DEFAULT;
		if (set_num == 8'h0b) begin
			case (var_idx)
				8'h03: value = 8'h03;
				8'h04: value = 8'h02;
				8'h09: value = 8'h58;
				8'h0d: value = 8'h01;
				8'h38: value = 8'h3d;
				8'h3a: value = 8'haa;
				8'h70: value = 8'h24;
				8'h7c: value = 8'h80;
				8'h98: value = 8'h40;
				default: hit = 1'b0;
			endcase
		end else if (set_num == 8'h0c) begin
			case (var_idx)
				8'h03: value = 8'h0f;
				8'h04: value = 8'h08;
				8'h06: value = 8'h78;
				8'h23: value = 8'h0c;
				8'h24: value = 8'h30;
				8'h7c: value = 8'h02;
				8'h7f: value = 8'h02;
				8'h80: value = 8'h01;
				8'h81: value = 8'haa;
				8'h82: value = 8'h24;
				8'h9b: value = 8'h04;
				8'h9c: value = 8'h04;
				default: hit = 1'b0;
			endcase
		end else if (set_num == 8'h0d) begin
			case (var_idx)
				8'h03: value = 8'h0a;
				8'h04: value = 8'h07;
				8'h23: value = 8'h00;
				8'h24: value = 8'h00;
				8'h25: value = 8'h00;
				8'h3d: value = 8'h61;
				8'h7c: value = 8'h04;
				8'h9b: value = 8'h04;
				8'h9c: value = 8'h04;
				default: hit = 1'b0;
			endcase
		end else if (common) begin
			case (var_idx)
				8'h02: value = 8'h04;
				8'h03: value = 8'h06;
				8'h04: value = 8'h02;
				8'h05: value = 8'hfc;
				8'h06: value = 8'h55;
				8'h09: value = 8'h5f;
				8'h0a: value = 8'h80;
				8'h38: value = 8'h21;
				8'h70: value = 8'h40;
				8'h71: value = 8'hff;
				8'h7a: value = 8'h1f;
				8'h90: value = 8'h80;
				8'h92: value = 8'h1e;
				8'h96: value = 8'hff;
				default: hit = 1'b0;
			endcase
		end else begin
			// No set selected
			hit = 1'b0;
		end
	end
endmodule : cvl_preset_table
`default_nettype wire
